// File: hdl/epfc_defs.svh
// Constants for the port flow-control and policer block
`ifndef EPFC_DEFS_SVH
`define EPFC_DEFS_SVH
`define EPFC_MAXLEN_RST 14'h05F2
`define EPFC_SPEED_RST 2'h1
`define EPFC_CIR_RST 24'h000400
`define EPFC_CBS_RST 24'h010000
`define EPFC_EBS_RST 24'h010000
`define EPFC_PAUSE_QUANTA_RST 16'hFFFF
`define EPFC_ETH_ADDR_W 14
`endif

// File: hdl/epfc_pkg.sv
// Types for the port flow-control and policer block
`default_nettype none
package epfc_pkg;
  typedef enum logic [1:0] {
    EPFC_SPD_100 = 2'b00,
    EPFC_SPD_1000 = 2'b01,
    EPFC_SPD_10000 = 2'b10
  } epfc_speed_t;
  typedef enum logic [1:0] {
    EPFC_POL_IDLE = 2'b00,
    EPFC_POL_PASS = 2'b01,
    EPFC_POL_DROP = 2'b10
  } epfc_pol_t;
endpackage
`default_nettype wire

// File: hdl/epfc_bucket_if.sv
// Interface between the port top and its token-bucket policer
`timescale 1ns/1ps
`default_nettype none
interface epfc_bucket_if;
  logic [23:0] cir;
  logic [23:0] cbs;
  logic [23:0] ebs;
  logic frame_req;
  logic [13:0] frame_len;
  logic frame_pass;
  logic frame_drop;
  logic [23:0] committed_level;
  logic [23:0] excess_level;
  modport port (output cir, cbs, ebs, frame_req, frame_len,
    input frame_pass, frame_drop, committed_level, excess_level);
  modport bucket (input cir, cbs, ebs, frame_req, frame_len,
    output frame_pass, frame_drop, committed_level, excess_level);
endinterface // epfc_bucket_if
`default_nettype wire

// File: hdl/epfc_bucket.sv
// Committed and excess token buckets that police ingress frames
`timescale 1ns/1ps
`default_nettype none
module epfc_bucket (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Rate tick, one per credit interval
  input wire logic i_tick,
  // Policer channel
  epfc_bucket_if.bucket bus
);
  logic [23:0] c_reg;
  logic [23:0] e_reg;
  logic [23:0] c_next;
  logic [23:0] e_next;
  logic [23:0] c_fill;
  logic [23:0] e_fill;
  logic [24:0] c_sum;
  logic [25:0] e_sum;
  logic [24:0] ovf;
  logic [23:0] bits;
  logic pass_next;
  logic drop_next;

  // Credit add saturates at the committed burst; overflow spills to excess
  always_comb begin
    c_sum = {1'b0, c_reg} + (i_tick ? {1'b0, bus.cir} : 25'h0000000);
    ovf = (c_sum > {1'b0, bus.cbs}) ? c_sum - {1'b0, bus.cbs} : 25'h0000000;
    c_fill = (c_sum > {1'b0, bus.cbs}) ? bus.cbs : c_sum[23:0];
    e_sum = {2'b00, e_reg} + {1'b0, ovf};
    e_fill = (e_sum > {2'b00, bus.ebs}) ? bus.ebs : e_sum[23:0];
    bits = {7'h00, bus.frame_len, 3'h0};
    c_next = c_fill;
    e_next = e_fill;
    pass_next = 1'b0;
    drop_next = 1'b0;
    // Spend after the fill, so a tick in the same cycle is never lost
    if (bus.frame_req) begin
      if (bits <= c_fill) begin
        c_next = c_fill - bits;
        pass_next = 1'b1;
      end else if (bits <= e_fill) begin
        e_next = e_fill - bits;
        pass_next = 1'b1;
      end else begin
        drop_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_reg <= 24'h000000;
      e_reg <= 24'h000000;
      bus.frame_pass <= 1'b0;
      bus.frame_drop <= 1'b0;
    end else if (i_ce) begin
      c_reg <= c_next;
      e_reg <= e_next;
      bus.frame_pass <= pass_next;
      bus.frame_drop <= drop_next;
    end
  end

  assign bus.committed_level = c_reg;
  assign bus.excess_level = e_reg;

  // ==========================================================
  // Checks
  excess_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_ce) |-> (e_reg <= bus.ebs || $changed(bus.ebs))) else $error("excess over cap");
  pass_drop_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(bus.frame_pass && bus.frame_drop)) else $error("pass and drop together");
  spend_credit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && bus.frame_req && bits <= c_fill) |=> bus.frame_pass)
    else $error("committed frame not passed");
  drop_cov: cover property (@(posedge i_clk) bus.frame_drop);
endmodule // epfc_bucket
`default_nettype wire

// File: hdl/epfc_port.sv
// Per-port Ethernet settings, PAUSE flow control and policer top
// ==========================================================
// Function
// - Flow control on: send PAUSE when receive buffers congest, obey peer PAUSE.
// - Flow control off: never send PAUSE, drop received PAUSE frames silently.
// - Local enable alone decides PAUSE behaviour, no negotiation with peer.
// - Accept frames up to max size; size changes only while locked out of service.
// - Speed changes only while locked out of service.
// - Mismatch alarm while media type does not suit module; clears on match.
// - Committed information rate guaranteed; changes only while locked.
// - Committed burst caps the committed credit in bits; changes only while locked.
// - Read-only port identifier slot-port plus gigabit or ten-gigabit rate.
// - Unused committed credit accumulates up to excess burst and is spent later.
`timescale 1ns/1ps
`default_nettype none
`include "epfc_defs.svh"
module epfc_port #(
  parameter logic [3:0] SLOT_ID = 4'h1,
  parameter logic [3:0] PORT_ID = 4'h1,
  parameter logic TEN_GIG_CARD = 1'b0
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Management settings
  input wire logic I_OOS_LOCKED,
  input wire logic I_FLOW_CTRL_EN,
  input wire logic I_MAXLEN_WR,
  input wire logic [13:0] I_MAXLEN,
  input wire logic I_SPEED_WR,
  input wire logic [1:0] I_SPEED,
  input wire logic I_CIR_WR,
  input wire logic [23:0] I_CIR,
  input wire logic I_CBS_WR,
  input wire logic [23:0] I_CBS,
  input wire logic I_EBS_WR,
  input wire logic [23:0] I_EBS,
  input wire logic I_MEDIA_WR,
  input wire logic [3:0] I_MEDIA,
  input wire logic [3:0] I_MODULE_MEDIA,
  input wire logic I_RATE_TICK,
  // Receive side
  input wire logic I_RX_CONGESTED,
  input wire logic I_RX_FRAME_END,
  input wire logic [13:0] I_RX_FRAME_LEN,
  input wire logic I_RX_IS_PAUSE,
  input wire logic [15:0] I_RX_PAUSE_QUANTA,
  // Transmit side
  input wire logic I_TX_PAUSE_ACK,
  output logic O_TX_PAUSE_REQ,
  output logic [15:0] O_TX_PAUSE_QUANTA,
  output logic O_TX_HOLD,
  // Frame verdicts
  output logic O_RX_ACCEPT,
  output logic O_RX_DISCARD,
  // Status
  output logic [13:0] O_MAXLEN,
  output logic [1:0] O_SPEED,
  output logic [23:0] O_CIR,
  output logic [23:0] O_CBS,
  output logic [23:0] O_EBS,
  output logic O_PROVISIONING_MISMATCH_ALARM_ALARM,
  output logic [8:0] O_PORT_ID,
  output logic [23:0] O_CREDIT_LEVEL
);
  logic [13:0] maxlen_reg;
  logic [1:0] speed_reg;
  logic [23:0] cir_reg;
  logic [23:0] cbs_reg;
  logic [23:0] ebs_reg;
  logic [3:0] media_reg;
  logic alarm_reg;
  logic cong_reg;
  logic pause_req_reg;
  logic [15:0] hold_reg;
  logic accept_reg;
  logic discard_reg;
  logic reject_reg;
  epfc_bucket_if bkt ();

  // Locked-only writes take effect only while out of service
  function automatic logic lock_ok(input logic wr, input logic locked);
    return wr && locked;
  endfunction

  // ==========================================================
  // Provisioned settings
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      maxlen_reg <= `EPFC_MAXLEN_RST;
      speed_reg <= `EPFC_SPEED_RST;
      cir_reg <= `EPFC_CIR_RST;
      cbs_reg <= `EPFC_CBS_RST;
      ebs_reg <= `EPFC_EBS_RST;
    end else if (I_CE) begin
      if (lock_ok(I_MAXLEN_WR, I_OOS_LOCKED)) maxlen_reg <= I_MAXLEN;
      if (lock_ok(I_SPEED_WR, I_OOS_LOCKED)) speed_reg <= I_SPEED;
      if (lock_ok(I_CIR_WR, I_OOS_LOCKED)) cir_reg <= I_CIR;
      if (lock_ok(I_CBS_WR, I_OOS_LOCKED)) cbs_reg <= I_CBS;
      if (lock_ok(I_EBS_WR, I_OOS_LOCKED)) ebs_reg <= I_EBS;
    end
  end

  // ==========================================================
  // Media type and mismatch alarm
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      media_reg <= 4'h0;
      alarm_reg <= 1'b0;
    end else if (I_CE) begin
      if (I_MEDIA_WR) media_reg <= I_MEDIA;
      // Zero module code means no module fitted, so nothing can mismatch
      alarm_reg <= (I_MODULE_MEDIA != 4'h0) && (media_reg != I_MODULE_MEDIA);
    end
  end

  // ==========================================================
  // PAUSE transmit: edge on congestion, independent of peer setting
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cong_reg <= 1'b0;
      pause_req_reg <= 1'b0;
    end else if (I_CE) begin
      cong_reg <= I_RX_CONGESTED;
      if (!I_FLOW_CTRL_EN)
        pause_req_reg <= 1'b0;
      else if (I_RX_CONGESTED && !cong_reg)
        pause_req_reg <= 1'b1;
      else if (I_TX_PAUSE_ACK)
        pause_req_reg <= 1'b0;
    end
  end

  // ==========================================================
  // PAUSE receive: hold transmit for the quanta, or discard
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_reg <= 16'h0000;
    end else if (I_CE) begin
      if (!I_FLOW_CTRL_EN)
        hold_reg <= 16'h0000;
      else if (I_RX_FRAME_END && I_RX_IS_PAUSE)
        hold_reg <= I_RX_PAUSE_QUANTA;
      else if (hold_reg != 16'h0000)
        hold_reg <= hold_reg - 16'h0001;
    end
  end

  // ==========================================================
  // Frame admission: size check, then policer verdict
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      accept_reg <= 1'b0;
      discard_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else if (I_CE) begin
      reject_reg <= 1'b0;
      if (I_RX_FRAME_END) begin
        // PAUSE frames are consumed here, never forwarded
        if (I_RX_IS_PAUSE)
          reject_reg <= 1'b1;
        else if (I_RX_FRAME_LEN > maxlen_reg)
          reject_reg <= 1'b1;
      end
      // Early rejects wait a cycle so verdicts keep frame order and never collide
      accept_reg <= bkt.frame_pass;
      discard_reg <= reject_reg || bkt.frame_drop;
    end
  end

  assign bkt.cir = cir_reg;
  assign bkt.cbs = cbs_reg;
  assign bkt.ebs = ebs_reg;
  assign bkt.frame_req = I_RX_FRAME_END && !I_RX_IS_PAUSE && (I_RX_FRAME_LEN <= maxlen_reg);
  assign bkt.frame_len = I_RX_FRAME_LEN;

  epfc_bucket u_bucket (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_tick(I_RATE_TICK),
    .bus(bkt.bucket)
  );

  assign O_TX_PAUSE_REQ = pause_req_reg;
  assign O_TX_PAUSE_QUANTA = `EPFC_PAUSE_QUANTA_RST;
  assign O_TX_HOLD = (hold_reg != 16'h0000);
  assign O_RX_ACCEPT = accept_reg;
  assign O_RX_DISCARD = discard_reg;
  assign O_MAXLEN = maxlen_reg;
  assign O_SPEED = speed_reg;
  assign O_CIR = cir_reg;
  assign O_CBS = cbs_reg;
  assign O_EBS = ebs_reg;
  assign O_PROVISIONING_MISMATCH_ALARM_ALARM = alarm_reg;
  assign O_PORT_ID = {SLOT_ID, PORT_ID, TEN_GIG_CARD};
  assign O_CREDIT_LEVEL = bkt.committed_level;

  // ==========================================================
  // Checks
  locked_maxlen_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && !I_OOS_LOCKED) |=> $stable(maxlen_reg)) else $error("max size moved in service");
  locked_speed_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && !I_OOS_LOCKED) |=> $stable(speed_reg)) else $error("speed moved in service");
  locked_rate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && !I_OOS_LOCKED) |=> ($stable(cir_reg) && $stable(cbs_reg) && $stable(ebs_reg)))
    else $error("rate moved in service");
  no_pause_off_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && !I_FLOW_CTRL_EN) |=> (!O_TX_PAUSE_REQ && !O_TX_HOLD))
    else $error("pause active while disabled");
  pause_on_cong_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && I_FLOW_CTRL_EN && I_RX_CONGESTED && !cong_reg) |=> O_TX_PAUSE_REQ)
    else $error("no pause on congestion");
  honor_pause_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && I_FLOW_CTRL_EN && I_RX_FRAME_END && I_RX_IS_PAUSE
     && I_RX_PAUSE_QUANTA != 16'h0000) |=> O_TX_HOLD)
    else $error("peer pause ignored");
  oversize_drop_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && I_RX_FRAME_END && I_RX_FRAME_LEN > maxlen_reg) ##1 I_CE
    |=> (O_RX_DISCARD && !O_RX_ACCEPT))
    else $error("oversize frame kept");
  alarm_track_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_CE && I_MODULE_MEDIA != 4'h0 && media_reg != I_MODULE_MEDIA) |=> O_PROVISIONING_MISMATCH_ALARM_ALARM)
    else $error("mismatch not raised");
  pause_cov: cover property (@(posedge I_CLOCK) O_TX_PAUSE_REQ && I_TX_PAUSE_ACK);
  hold_cov: cover property (@(posedge I_CLOCK) O_TX_HOLD);
  accept_cov: cover property (@(posedge I_CLOCK) O_RX_ACCEPT);
  alarm_cov: cover property (@(posedge I_CLOCK) $fell(O_PROVISIONING_MISMATCH_ALARM_ALARM));
endmodule // epfc_port
`default_nettype wire

// File: testbench/epfc_peer.sv
// Peer port model: sends frames and answers local PAUSE requests
`timescale 1ns/1ps
`default_nettype none
module epfc_peer (
  // Clock
  input wire logic i_clk,
  // PAUSE request from the port and its sent acknowledge
  input wire logic i_req,
  input wire logic [7:0] i_ack_dly,
  output logic o_ack,
  // Frames toward the port
  output logic o_end,
  output logic [13:0] o_len,
  output logic o_pause,
  output logic [15:0] o_quanta
);
  // ==========================================================
  // Peer has no flow-control setting of its own, it is never asked
  initial begin
    o_ack = 1'b0;
    o_end = 1'b0;
    o_len = 14'h0000;
    o_pause = 1'b0;
    o_quanta = 16'h0000;
  end
  // Ack delay is steerable, so replies can be prompt or slow
  always @(negedge i_clk) begin
    if (i_req === 1'b1 && o_ack === 1'b0) begin
      repeat (i_ack_dly) @(negedge i_clk);
      o_ack <= 1'b1;
      @(negedge i_clk);
      o_ack <= 1'b0;
      @(negedge i_clk);
    end
  end
  // Length and quanta go stale after the strobe, so they are inverted
  task automatic send(input logic [13:0] len, input logic pause, input logic [15:0] q);
    @(negedge i_clk);
    o_end = 1'b1;
    o_len = len;
    o_pause = pause;
    o_quanta = q;
    @(negedge i_clk);
    o_end = 1'b0;
    o_len = ~o_len;
    o_quanta = ~o_quanta;
  endtask
endmodule // epfc_peer
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the port settings, PAUSE and policer block
`timescale 1ns/1ps
`default_nettype none
`include "epfc_defs.svh"
module testbench;
  // ==========================================================
  // Stimulus, expectations and checks
  logic clk, rst_n, lock, fc, tick, cong, ack, req, hold, acc, disc, alarm, f_end, f_pause, ce;
  logic [5:0] stb;
  logic [23:0] dat, cir, cbs, ebs, credit;
  logic [13:0] maxlen, f_len;
  logic [1:0] speed;
  logic [3:0] mod_media;
  logic [15:0] quanta, f_q, lfsr;
  logic [8:0] pid;
  logic [7:0] dly;
  logic [23:0] ev [5];
  logic exp_q [$];
  int bad_count, checked;
  epfc_port #(.SLOT_ID(4'h3), .PORT_ID(4'h2), .TEN_GIG_CARD(1'b1)) i_epfc_port (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_OOS_LOCKED(lock), .I_FLOW_CTRL_EN(fc),
    .I_MAXLEN_WR(stb[0]), .I_MAXLEN(dat[13:0]), .I_SPEED_WR(stb[1]), .I_SPEED(dat[1:0]),
    .I_CIR_WR(stb[2]), .I_CIR(dat), .I_CBS_WR(stb[3]), .I_CBS(dat), .I_EBS_WR(stb[4]),
    .I_EBS(dat), .I_MEDIA_WR(stb[5]), .I_MEDIA(dat[3:0]), .I_MODULE_MEDIA(mod_media),
    .I_RATE_TICK(tick), .I_RX_CONGESTED(cong), .I_RX_FRAME_END(f_end), .I_RX_FRAME_LEN(f_len),
    .I_RX_IS_PAUSE(f_pause), .I_RX_PAUSE_QUANTA(f_q), .I_TX_PAUSE_ACK(ack),
    .O_TX_PAUSE_REQ(req), .O_TX_PAUSE_QUANTA(quanta), .O_TX_HOLD(hold), .O_RX_ACCEPT(acc),
    .O_RX_DISCARD(disc), .O_MAXLEN(maxlen), .O_SPEED(speed), .O_CIR(cir), .O_CBS(cbs),
    .O_EBS(ebs), .O_PROVISIONING_MISMATCH_ALARM_ALARM(alarm), .O_PORT_ID(pid), .O_CREDIT_LEVEL(credit));
  epfc_peer i_epfc_peer (.i_clk(clk), .i_req(req), .i_ack_dly(dly), .o_ack(ack),
    .o_end(f_end), .o_len(f_len), .o_pause(f_pause), .o_quanta(f_q));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input int k, input logic [23:0] d);
    @(negedge clk);
    stb[k] = 1'b1;
    dat = d;
    @(negedge clk);
    stb = 6'h00;
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask
  // Verdict is noted before the frame leaves the peer
  task automatic frm(input logic [13:0] len, input logic p, input logic e);
    exp_q.push_back(e);
    i_epfc_peer.send(len, p, 16'h0014);
    repeat (3) @(negedge clk);
  endtask
  task automatic cmp_set();
    chk("maxlen", ev[0], {10'h000, maxlen});
    chk("speed", ev[1], {22'h000000, speed});
    chk("cir", ev[2], cir);
    chk("cbs", ev[3], cbs);
    chk("ebs", ev[4], ebs);
  endtask
  always @(negedge clk) begin
    logic [1:0] e;
    if (acc === 1'b1 || disc === 1'b1) begin
      e = 2'b11;
      if (exp_q.size() > 0) begin
        e[1] = exp_q.pop_front();
        e[0] = ~e[1];
      end
      chk("verdict", {22'h000000, e}, {22'h000000, acc, disc});
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {rst_n, lock, fc, tick, cong, stb, dat, dly} = '0;
    mod_media = 4'h3;
    ce = 1'b1;
    lfsr = 16'hDD30;
    ev = '{`EPFC_MAXLEN_RST, `EPFC_SPEED_RST, `EPFC_CIR_RST, `EPFC_CBS_RST, `EPFC_EBS_RST};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    cmp_set();
    chk("port_id", {15'h0000, 4'h3, 4'h2, 1'b1}, {15'h0000, pid});
    ev = '{24'h40, 24'(epfc_pkg::EPFC_SPD_10000), 24'h100, 24'h200, 24'h400};
    lock = 1'b1;
    for (int k = 0; k < 5; k++) wr(k, ev[k]);
    lock = 1'b0;
    cmp_set();
    for (int k = 0; k < 5; k++) begin
      lfsr = nxt(lfsr);
      wr(k, {8'h00, lfsr});
    end
    cmp_set();
    // Frozen clock enable must swallow even a locked write
    lock = 1'b1;
    ce = 1'b0;
    wr(0, 24'h30);
    cmp_set();
    ce = 1'b1;
    lock = 1'b0;
    // Third tick overflows committed credit into the excess bucket
    tk(1);
    chk("credit", 24'h100, credit);
    tk(3);
    chk("credit", 24'h200, credit);
    frm(14'h41, 1'b0, 1'b0);
    chk("credit", 24'h200, credit);
    frm(14'h40, 1'b0, 1'b1);
    chk("credit", 24'h0, credit);
    frm(14'h20, 1'b0, 1'b1);
    frm(14'h20, 1'b0, 1'b1);
    frm(14'h20, 1'b0, 1'b0);
    fc = 1'b1;
    dly = 8'h05;
    @(negedge clk);
    cong = 1'b1;
    repeat (2) @(negedge clk);
    chk("pause_req", 24'h1, {23'h0, req});
    chk("pause_quanta", 24'hFFFF, {8'h00, quanta});
    repeat (10) @(negedge clk);
    chk("pause_req", 24'h0, {23'h0, req});
    frm(14'h40, 1'b1, 1'b0);
    chk("hold", 24'h1, {23'h0, hold});
    repeat (25) @(negedge clk);
    chk("hold", 24'h0, {23'h0, hold});
    fc = 1'b0;
    cong = 1'b0;
    @(negedge clk);
    cong = 1'b1;
    repeat (3) @(negedge clk);
    chk("pause_req", 24'h0, {23'h0, req});
    frm(14'h40, 1'b1, 1'b0);
    chk("hold", 24'h0, {23'h0, hold});
    wr(5, 24'h3);
    @(negedge clk);
    chk("alarm", 24'h0, {23'h0, alarm});
    lfsr = nxt(lfsr);
    wr(5, (lfsr[3:0] == 4'h3) ? 24'h5 : {20'h0, lfsr[3:0]});
    @(negedge clk);
    chk("alarm", 24'h1, {23'h0, alarm});
    // No module fitted: nothing can mismatch
    mod_media = 4'h0;
    @(negedge clk);
    chk("alarm", 24'h0, {23'h0, alarm});
    chk("pending", 24'h0, 24'(exp_q.size()));
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
